// [pkg/can_rx_flag_map.svh]
// offsets, field positions, reset values and limits of the receiver flag block
`ifndef CAN_RX_FLAG_MAP_SVH
`define CAN_RX_FLAG_MAP_SVH

// register indices, byte address is four times the index
`define CTRL_IDX        8'h00
`define STAT_IDX        8'h01
`define RFLG_IDX        8'h04
`define RIER_IDX        8'h05

// control register fields
`define CTRL_INIT_BIT   0
`define CTRL_WAKE_BIT   1
`define CTRL_SLEEP_BIT  2

// status register fields
`define STAT_INIT_ACKNOWLEDGE_BIT 0
`define STAT_SLEEPAK_BIT 1

// flag and enable field positions
`define WAKE_BIT        7
`define CSC_BIT         6
`define RXST_HI         5
`define RXST_LO         4
`define TXST_HI         3
`define TXST_LO         2
`define OVR_BIT         1
`define RXF_BIT         0

// reset values
`define RIER_RESET      8'h00
`define CTRL_RESET      3'h0

// error counter limits
`define WARN_LIMIT      9'h060
`define ERR_LIMIT       9'h07F
`define BUSOFF_LIMIT    9'h0FF

// bus state codes
`define ST_OK           2'h0
`define ST_WARN         2'h1
`define ST_ERR          2'h2
`define ST_BUSOFF       2'h3

// sensitivity codes
`define SENS_NONE       2'h0
`define SENS_BUSOFF     2'h1
`define SENS_ERR        2'h2
`define SENS_ALL        2'h3

`endif

// [pkg/can_rx_flag_pkg.sv]
// types of the receiver flag block
package can_rx_flag_pkg;

  typedef logic [1:0] bus_state_t;

  typedef struct packed {
    logic        wakeFlag;
    logic        statusChangeFlag;
    bus_state_t  rxStateField;
    bus_state_t  txStateField;
    logic        overrunFlag;
    logic        rxFullFlag;
    logic [7:0]  irqEnables;
    logic        initRequest;
    logic        wakeEnable;
    logic        sleepRequest;
    logic [31:0] readData;
  } state_s;

endpackage

// [design/bus_state_encoder.sv]
// maps error counters to a two-bit bus state code
`timescale 1ns/1ps
`include "can_rx_flag_map.svh"

module bus_state_encoder #(
  parameter bit RX_SIDE = 1'b0
) (
  // counters
  input  wire logic [8:0]                  errCount,
  input  wire logic [8:0]                  txErrCount,
  // code
  output      can_rx_flag_pkg::bus_state_t stateCode
);

  always_comb
  begin
    if (txErrCount > `BUSOFF_LIMIT)
      stateCode = `ST_BUSOFF;                 // see RL11
    else if (errCount <= `WARN_LIMIT)
      stateCode = `ST_OK;                     // see RL8 see RL9
    else if (errCount <= `ERR_LIMIT)
      stateCode = `ST_WARN;                   // see RL8 see RL9
    else
      stateCode = `ST_ERR;
    if (RX_SIDE && txErrCount <= `BUSOFF_LIMIT && errCount > `ERR_LIMIT)
      stateCode = `ST_ERR;
  end

endmodule // bus_state_encoder

// [design/state_change_filter.sv]
// decides whether a state change is reported under a sensitivity level
`timescale 1ns/1ps
`include "can_rx_flag_map.svh"

module state_change_filter (
  // states
  input  wire can_rx_flag_pkg::bus_state_t oldState,
  input  wire can_rx_flag_pkg::bus_state_t newState,
  // sensitivity
  input  wire logic [1:0]                  sensitivity,
  // result
  output      logic                        hit
);

  always_comb
  begin
    case (sensitivity)                                           // see RL19
      `SENS_NONE:   hit = 1'b0;
      `SENS_BUSOFF: hit = (oldState == `ST_BUSOFF) != (newState == `ST_BUSOFF);
      `SENS_ERR:    hit = (oldState >= `ST_ERR) != (newState >= `ST_ERR);
      `SENS_ALL:    hit = oldState != newState;
      default:      hit = 1'b0;
    endcase
  end

endmodule // state_change_filter

// [design/can_rx_flag_irq_enable.sv]
// receiver flags, interrupt enables and requests with an apb register port
//
// Contract
// RL1 - write one clears flag, state fields read-only
// RL2 - init mode forces flags reset, ignores writes
// RL3 - flags writable again once init cleared
// RL4 - bus activity in sleep sets wake flag
// RL5 - wake request while flag and enable set
// RL6 - status change sets flag, error request
// RL7 - state fields frozen while change flag pending
// RL8 - receiver state coding from error counters
// RL9 - transmitter state coding from error counters
// RL10 - state fields ignore initialization mode
// RL11 - transmitter bus-off forces receiver bus-off
// RL12 - overrun sets flag, error request
// RL13 - correct message shifted sets receive-full flag
// RL14 - receive-full flag blocks next foreground shift
// RL15 - receive request while flag and enable set
// RL16 - software reads buffer only when full
// RL17 - enable register layout, all reset zero
// RL18 - enables held reset in init mode
// RL19 - sensitivity selects which changes set flag
// RL20 - clear takes effect only without set cause (status change and receive-full flags clear even with a set cause pending)
// RL21 - three requests: wake, error, receive
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "can_rx_flag_map.svh"

module can_rx_flag_irq_enable (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // protocol core status and events
  input  wire logic        initAck,
  input  wire logic        sleepAck,
  input  wire logic        busActivity,
  input  wire logic [8:0]  txErrCount,
  input  wire logic [7:0]  rxErrCount,
  input  wire logic        overrunEvt,
  input  wire logic        msgShifted,
  // protocol core control
  output      logic        initRequest,
  output      logic        sleepRequest,
  output      logic        shiftBlock,
  // interrupt requests
  output      logic        irqWake,
  output      logic        irqError,
  output      logic        irqRx
);

  can_rx_flag_pkg::state_s     state_r;
  can_rx_flag_pkg::state_s     state_nxt;
  can_rx_flag_pkg::bus_state_t rxLive;
  can_rx_flag_pkg::bus_state_t txLive;
  logic                        rxHit;
  logic                        txHit;
  logic                        initMode;
  logic                        writeOk;
  logic                        setupPhase;
  logic                        accessPhase;
  logic                        mapped;
  logic                        wrFlags;
  logic                        wrEnables;
  logic                        wrCtrl;
  logic [7:0]                  clrMask;
  logic                        setWake;
  logic                        setCsc;
  logic                        setOvr;
  logic                        setRxf;

  function automatic logic [7:0] regAddr(input logic [7:0] idx);
    regAddr = {idx[5:0], 2'b00};
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == regAddr(`CTRL_IDX)) || (addr == regAddr(`STAT_IDX)) ||
               (addr == regAddr(`RFLG_IDX)) || (addr == regAddr(`RIER_IDX));
  endfunction

  // live bus state from the error counters
  bus_state_encoder #(
    .RX_SIDE (1'b1)
  ) rxEncoder (
    .errCount   ({1'b0, rxErrCount}),
    .txErrCount (txErrCount),
    .stateCode  (rxLive)
  );

  bus_state_encoder #(
    .RX_SIDE (1'b0)
  ) txEncoder (
    .errCount   (txErrCount),
    .txErrCount (txErrCount),
    .stateCode  (txLive)
  );

  // reported changes under the chosen sensitivity
  state_change_filter rxFilter (
    .oldState    (state_r.rxStateField),
    .newState    (rxLive),
    .sensitivity (state_r.irqEnables[`RXST_HI:`RXST_LO]),
    .hit         (rxHit)
  );

  state_change_filter txFilter (
    .oldState    (state_r.txStateField),
    .newState    (txLive),
    .sensitivity (state_r.irqEnables[`TXST_HI:`TXST_LO]),
    .hit         (txHit)
  );

  // init mode and write permission
  assign initMode = state_r.initRequest & initAck;               // see RL2
  assign writeOk  = ~state_r.initRequest & ~initAck;             // see RL3

  // apb decode
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign mapped      = isMapped(paddr);
  assign wrFlags     = accessPhase & pwrite & pstrb[0] & writeOk &
                       (paddr == regAddr(`RFLG_IDX));
  assign wrEnables   = accessPhase & pwrite & pstrb[0] & writeOk &
                       (paddr == regAddr(`RIER_IDX));
  assign wrCtrl      = accessPhase & pwrite & pstrb[0] &
                       (paddr == regAddr(`CTRL_IDX));

  // write one clears, state field bits never cleared by software
  assign clrMask = wrFlags ? (pwdata[7:0] & 8'hC3) : 8'h00;      // see RL1

  // set causes
  assign setWake = busActivity & sleepAck & state_r.wakeEnable;  // see RL4
  assign setOvr  = overrunEvt;                                   // see RL12
  assign setRxf  = msgShifted & ~state_r.rxFullFlag;             // see RL13
  assign setCsc  = ~state_r.statusChangeFlag & (rxHit | txHit);  // see RL6

  always_comb
  begin
    state_nxt = state_r;

    // control register, reachable in every mode
    if (wrCtrl)
    begin
      state_nxt.initRequest  = pwdata[`CTRL_INIT_BIT];
      state_nxt.wakeEnable   = pwdata[`CTRL_WAKE_BIT];
      state_nxt.sleepRequest = pwdata[`CTRL_SLEEP_BIT];
    end

    // state fields follow the counters while no change is pending
    if (!state_r.statusChangeFlag)                               // see RL7 see RL10
    begin
      state_nxt.rxStateField = rxLive;
      state_nxt.txStateField = txLive;
    end

    // flags: wake and overrun set causes win over a simultaneous clear; change and full flags set only while low
    state_nxt.wakeFlag = setWake |
      (state_r.wakeFlag & ~clrMask[`WAKE_BIT]);                  // see RL20
    state_nxt.statusChangeFlag = setCsc |
      (state_r.statusChangeFlag & ~clrMask[`CSC_BIT]);           // see RL20
    state_nxt.overrunFlag = setOvr |
      (state_r.overrunFlag & ~clrMask[`OVR_BIT]);                // see RL20
    state_nxt.rxFullFlag = setRxf |
      (state_r.rxFullFlag & ~clrMask[`RXF_BIT]);                 // see RL14 see RL20

    // enables
    if (wrEnables)
      state_nxt.irqEnables = pwdata[7:0];                        // see RL17

    // init mode holds flags and enables in reset
    if (initMode)
    begin
      state_nxt.wakeFlag         = 1'b0;                         // see RL2
      state_nxt.statusChangeFlag = 1'b0;
      state_nxt.overrunFlag      = 1'b0;
      state_nxt.rxFullFlag       = 1'b0;
      state_nxt.irqEnables       = `RIER_RESET;                  // see RL18
    end

    // read data captured in the setup phase
    if (setupPhase && !pwrite)
    begin
      state_nxt.readData = 32'h0000_0000;
      case (paddr)
        regAddr(`CTRL_IDX):
        begin
          state_nxt.readData[`CTRL_INIT_BIT]  = state_r.initRequest;
          state_nxt.readData[`CTRL_WAKE_BIT]  = state_r.wakeEnable;
          state_nxt.readData[`CTRL_SLEEP_BIT] = state_r.sleepRequest;
        end
        regAddr(`STAT_IDX):
        begin
          state_nxt.readData[`STAT_INIT_ACKNOWLEDGE_BIT]  = initAck;
          state_nxt.readData[`STAT_SLEEPAK_BIT] = sleepAck;
        end
        regAddr(`RFLG_IDX):
          state_nxt.readData[7:0] = {state_r.wakeFlag, state_r.statusChangeFlag,
                                     state_r.rxStateField, state_r.txStateField,
                                     state_r.overrunFlag, state_r.rxFullFlag};
        regAddr(`RIER_IDX):
          state_nxt.readData[7:0] = state_r.irqEnables;
        default:
          state_nxt.readData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r              <= '0;
      state_r.irqEnables   <= `RIER_RESET;
      {state_r.sleepRequest, state_r.wakeEnable, state_r.initRequest} <= `CTRL_RESET;
    end
    else
      state_r <= state_nxt;
  end

  // bus answers
  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~mapped;
  assign prdata  = state_r.readData;

  // core control
  assign initRequest  = state_r.initRequest;
  assign sleepRequest = state_r.sleepRequest;
  assign shiftBlock   = state_r.rxFullFlag;                      // see RL14

  // interrupt requests
  assign irqWake  = state_r.wakeFlag & state_r.irqEnables[`WAKE_BIT];          // see RL5 see RL21
  assign irqError = (state_r.statusChangeFlag & state_r.irqEnables[`CSC_BIT]) |
                    (state_r.overrunFlag & state_r.irqEnables[`OVR_BIT]);      // see RL6 see RL12
  assign irqRx    = state_r.rxFullFlag & state_r.irqEnables[`RXF_BIT];         // see RL15 see RL21

endmodule // can_rx_flag_irq_enable

// [tb/can_rx_flag_irq_enable_properties.sv]
// assertions on the ports of the receiver flag block
`timescale 1ns/1ps
`include "can_rx_flag_map.svh"

module can_rx_flag_irq_enable_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // register port
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  // core side
  input wire logic        initAck,
  input wire logic        msgShifted,
  input wire logic        initRequest,
  input wire logic        shiftBlock,
  // requests
  input wire logic        irqWake,
  input wire logic        irqError,
  input wire logic        irqRx
);
  logic inInit;
  logic anyWr;
  logic clrRx;
  assign inInit = initRequest & initAck;
  assign anyWr  = psel & penable & pwrite;
  assign clrRx  = anyWr & pstrb[0] & pwdata[0] & ~initRequest & ~initAck
                  & (paddr == 8'(`RFLG_IDX * 4));

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_rx_set: assert property (msgShifted && !shiftBlock && !inInit |=> shiftBlock)
    else $error("full flag not set");
  a_rx_cause: assert property ($rose(shiftBlock) |-> $past(msgShifted))
    else $error("full flag without message");
  a_rx_hold: assert property (shiftBlock && !anyWr && !inInit |=> shiftBlock)
    else $error("full flag dropped");
  a_rx_clear: assert property (clrRx && !msgShifted |=> !shiftBlock)
    else $error("full flag not cleared");
  a_rx_irq: assert property (irqRx |-> shiftBlock)
    else $error("receive request without flag");
  a_init_quiet: assert property (
    inInit |=> !(shiftBlock || irqWake || irqError || irqRx))
    else $error("flags alive in init mode");
  a_wake_hold: assert property (irqWake && !anyWr && !inInit |=> irqWake)
    else $error("wake request dropped");
  a_err_hold: assert property (irqError && !anyWr && !inInit |=> irqError)
    else $error("error request dropped");
endmodule // can_rx_flag_irq_enable_properties

bind can_rx_flag_irq_enable can_rx_flag_irq_enable_properties u_props (.*);

// [tb/can_core_model.sv]
// behavioural protocol core: mode acknowledges and foreground shifts
`timescale 1ns/1ps

module can_core_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // control from block
  input  wire logic initRequest,
  input  wire logic sleepRequest,
  input  wire logic shiftBlock,
  // message waiting in fifo
  input  wire logic msgPending,
  // status to block
  output      logic initAck,
  output      logic sleepAck,
  output      logic msgShifted
);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      initAck    <= 1'b0;
      sleepAck   <= 1'b0;
      msgShifted <= 1'b0;
    end
    else
    begin
      initAck    <= initRequest;
      sleepAck   <= sleepRequest;
      msgShifted <= msgPending & ~shiftBlock & ~msgShifted;
    end
  end
endmodule // can_core_model

// [tb/can_rx_flag_irq_enable_tb_top.sv]
// register level tests of the receiver flag block
`timescale 1ns/1ps
`include "can_rx_flag_map.svh"

module can_rx_flag_irq_enable_tb_top;
  localparam logic [7:0] ACTL = 8'(`CTRL_IDX * 4);
  localparam logic [7:0] AFLG = 8'(`RFLG_IDX * 4);
  localparam logic [7:0] AIER = 8'(`RIER_IDX * 4);
  logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rxErrCount = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  pstrb = 4'hF;
  logic [8:0]  txErrCount = 9'h000;
  logic        busActivity = 1'b0, overrunEvt = 1'b0, msgPending = 1'b0, e;
  logic        pready, pslverr, initAck, sleepAck, msgShifted;
  logic        initRequest, sleepRequest, shiftBlock, irqWake, irqError, irqRx;
  int          n_fail = 0;
  int          total_checks = 0;
  // enables, rx count, tx count, expected flags
  logic [31:0] tbl [5][4] = '{'{32'h40, 0, 50, 32'h00}, '{32'h50, 100, 50, 32'h10},
                              '{32'h60, 130, 50, 32'h60}, '{32'h48, 130, 130, 32'h68},
                              '{32'h44, 130, 256, 32'h7C}};

  always #20 mclk = ~mclk;

  can_rx_flag_irq_enable DUT (.*);
  can_core_model core (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic ovr();
    @(posedge mclk);
    overrunEvt <= 1'b1;
    @(posedge mclk);
    overrunEvt <= 1'b0;
    settle(2);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(AIER, 32'h00);
    rd(AFLG, 32'h00);
    xfer(1'b0, 8'h30, 32'h0);
    chk(e, 1'b1);
    wr(AIER, 32'h02);
    ovr();
    chk(irqError, 1'b1);
    wr(AFLG, 32'h00);
    rd(AFLG, 32'h02);
    wr(AFLG, 32'h02);
    rd(AFLG, 32'h00);
    chk(irqError, 1'b0);
    $display("test overrun done");
    wr(AIER, 32'h01);
    msgPending <= 1'b1;
    settle(3);
    chk(irqRx, 1'b1);
    rd(AFLG, 32'h01);
    wr(AFLG, 32'h01);
    settle(3);
    chk(shiftBlock, 1'b1);
    @(posedge mclk);
    msgPending <= 1'b0;
    wr(AFLG, 32'h01);
    settle(2);
    chk(irqRx, 1'b0);
    $display("test receive done");
    wr(ACTL, 32'h06);
    wr(AIER, 32'h80);
    @(posedge mclk);
    busActivity <= 1'b1;
    @(posedge mclk);
    busActivity <= 1'b0;
    settle(2);
    chk(irqWake, 1'b1);
    wr(ACTL, 32'h00);
    wr(AFLG, 32'h80);
    rd(AFLG, 32'h00);
    $display("test wake done");
    wr(AIER, 32'h7C);
    @(posedge mclk);
    rxErrCount <= 8'd96;
    settle(2);
    rd(AFLG, 32'h00);
    rxErrCount <= 8'd97;
    settle(2);
    chk(irqError, 1'b1);
    rd(AFLG, 32'h50);
    rxErrCount <= 8'd128;
    settle(2);
    rd(AFLG, 32'h50);
    wr(AFLG, 32'h40);
    settle(2);
    rd(AFLG, 32'h60);
    txErrCount <= 9'd256;
    wr(AFLG, 32'h40);
    settle(2);
    rd(AFLG, 32'h7C);
    txErrCount <= 9'd97;
    rxErrCount <= 8'd0;
    wr(AFLG, 32'h40);
    settle(2);
    rd(AFLG, 32'h44);
    foreach (tbl[i])
    begin
      wr(AIER, tbl[i][0]);
      wr(AFLG, 32'hFF);
      @(posedge mclk);
      rxErrCount <= tbl[i][1][7:0];
      txErrCount <= tbl[i][2][8:0];
      settle(2);
      rd(AFLG, tbl[i][3]);
    end
    $display("test states done");
    wr(ACTL, 32'h01);
    settle(2);
    rd(AFLG, 32'h3C);
    wr(AIER, 32'hFF);
    rd(AIER, 32'h00);
    txErrCount <= 9'd50;
    ovr();
    rd(AFLG, 32'h20);
    wr(ACTL, 32'h00);
    settle(2);
    wr(AIER, 32'h02);
    rd(AIER, 32'h02);
    ovr();
    wr(AFLG, 32'h3E);
    rd(AFLG, 32'h20);
    $display("test init done");
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule // can_rx_flag_irq_enable_tb_top
